// >>> ismpl_params.svh
// Purpose: Offsets, field positions, reset values and counts of the interrupt status, mask and poll logic.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes: Definitions only; included by its bare name.
`ifndef ISMPL_PARAMS_SVH
`define ISMPL_PARAMS_SVH

// Register word indices (byte address = index * 4).
`define ISMPL_IDX_EOI      8'h22
`define ISMPL_IDX_POLL     8'h24
`define ISMPL_IDX_POLL_STATUS_VIEW   8'h26
`define ISMPL_IDX_MASK     8'h28
`define ISMPL_IDX_FLOOR    8'h2A
`define ISMPL_IDX_SERV     8'h2C
`define ISMPL_IDX_REQ      8'h2E
`define ISMPL_IDX_CFG      8'h38
`define ISMPL_IDX_PRLO     8'h39
`define ISMPL_IDX_PRHI     8'h3A

// Number of bit positions in the status layouts.
`define ISMPL_NPOS         11

// Mask reset values and writable bits per mode.
`define ISMPL_MASK_RST_M   11'h7FD
`define ISMPL_MASK_RST_S   11'h03D
`define ISMPL_MASK_WR_M    11'h7FD
`define ISMPL_MASK_WR_S    11'h03D

// Threshold and per-source priority reset values.
`define ISMPL_THR_RST      3'h7
`define ISMPL_PRIO_RST     33'h1FFFFFFFF

// Interrupt type of bit position zero; position p has type base + p.
`define ISMPL_TYPE_BASE    5'h08

// Field positions.
`define ISMPL_POLL_FLAG    15
`define ISMPL_GEN_END      15
`define ISMPL_EXT01_POS    11'h030
`define ISMPL_SLV_OTHER    9'h003

// Cycles the strap synchroniser needs before its output is trusted.
`define ISMPL_STRAP_WAIT   2'h3

`endif

// >>> ismpl_pkg.sv
// Purpose: Types shared by the interrupt status, mask and poll logic.
// Assumes: Constants live in ismpl_params.svh.
// Notes: Nothing here is imported; users write ismpl_pkg::name.
package ismpl_pkg;

   // One bit per status position, in the register layout of the active mode.
   typedef logic [10:0] ismpl_vec_t;

   // Strap capture sequence after reset release.
   typedef enum logic {
      ISMPL_STRAP_WAIT,
      ISMPL_STRAP_DONE
   } ismpl_strap_e;

endpackage : ismpl_pkg

// >>> ismpl_pick.sv
// Purpose: Pick the best candidate position by priority value.
// Assumes: Three-bit priority per position, packed at bits 3p+2..3p.
// Notes: Purely combinational; lower value wins, lower position breaks ties.
`timescale 1ns/1ps
`default_nettype none
`include "ismpl_params.svh"

module ismpl_pick (
   // Candidates and their priorities.
   input  wire logic [10:0] cand,
   input  wire logic [32:0] prio_flat,
   // Result.
   output logic             found,
   output logic [3:0]       pos,
   output logic [2:0]       prio
);

   // Linear scan; only a strictly better value replaces, so ties keep the lower position.
   always_comb begin
      found = 1'b0;
      pos   = 4'h0;
      prio  = 3'h7;
      for (int i = 0; i < `ISMPL_NPOS; i++) begin
         if (cand[i] && (!found || (prio_flat[3*i +: 3] < prio))) begin
            found = 1'b1;
            pos   = 4'(i);
            prio  = prio_flat[3*i +: 3];
         end
      end
   end

endmodule : ismpl_pick

`default_nettype wire

// >>> ismpl_top.sv
// Purpose: Request, in-service, mask, threshold and poll logic of an interrupt controller.
// Assumes: Request inputs and the core acknowledge come from logic on pclk; the mode strap is a pin.
// Notes: APB slave, one wait-free access cycle; prdata is captured in the setup cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ismpl_params.svh"

module ismpl_top (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Mode strap pin, high for master mode.
   input  wire logic        master_strap,
   // On-chip request sources.
   input  wire logic [2:0]  timer_req,
   input  wire logic [1:0]  dma_req,
   input  wire logic [4:0]  ext_req,
   input  wire logic        wdog_req,
   input  wire logic        serial_req,
   // Processor core side.
   output logic             irq_req,
   output logic [4:0]       irq_type,
   input  wire logic        irq_ack
);

   // Mode view of the three timers and the other sources.
   function automatic ismpl_pkg::ismpl_vec_t view(input logic m, input logic [2:0] t, input logic [10:2] o);
      view = m ? {o, 1'b0, |t} : {5'h00, t[2], t[1], o[3:2], 1'b0, t[0]};
   endfunction : view

   // Spread a layout vector back onto lanes {others[10:2], timers[2:0]}.
   function automatic logic [11:0] unview(input logic m, input ismpl_pkg::ismpl_vec_t v);
      unview = m ? {v[10:2], {3{v[0]}}} : {7'h00, v[3:2], v[5], v[4], v[0]};
   endfunction : unview

   // One-hot vector of a position.
   function automatic ismpl_pkg::ismpl_vec_t onehot(input logic [3:0] p);
      onehot = 11'h001 << p;
   endfunction : onehot

   // Strap synchroniser and capture state.
   logic                    strap_s1;       // First stage, read only by strap_s2.
   logic                    strap_s2;       // Second stage.
   logic                    strap_s3;       // Third stage.
   logic [1:0]              strap_cnt;      // Settling count.
   ismpl_pkg::ismpl_strap_e strap_state;    // Capture progress.
   logic                    master;         // Captured mode.
   logic                    sfnm;           // Special fully nested mode enable.

   // Sticky pending and in-service lanes.
   logic [2:0]              pend_t;         // Timer requests.
   logic [10:2]             pend_o;         // DMA, external, watchdog, serial requests.
   logic [2:0]              serv_t;         // Timer in-service.
   logic [10:2]             serv_o;         // Other in-service.

   // Software-set controls.
   ismpl_pkg::ismpl_vec_t   mask;           // Source mask, one masks.
   logic [2:0]              thr;            // Priority threshold.
   logic [32:0]             prio_flat;      // Per-position priority fields.

   // Registered winner shown to the core and to polling.
   logic                    win_valid;
   logic [3:0]              win_pos;
   logic [4:0]              win_type;

   // APB capture made in the setup cycle.
   logic                    err_q;
   logic                    poll_hit;
   logic [3:0]              poll_pos;

   // Views, candidates and arbitration results.
   ismpl_pkg::ismpl_vec_t   pend_v;
   ismpl_pkg::ismpl_vec_t   serv_v;
   ismpl_pkg::ismpl_vec_t   pass_thr;
   ismpl_pkg::ismpl_vec_t   lvl_eq;
   ismpl_pkg::ismpl_vec_t   blocked;
   ismpl_pkg::ismpl_vec_t   cand;
   wire logic               strap_done = (strap_state == ismpl_pkg::ISMPL_STRAP_DONE);
   logic                    req_found;
   logic [3:0]              req_pos;
   logic [2:0]              req_prio;
   logic                    srv_found;
   logic [3:0]              srv_pos;

   assign pend_v = view(master, pend_t, pend_o);
   assign serv_v = view(master, serv_t, serv_o);

   // Threshold and level compare for each position.
   for (genvar g = 0; g < `ISMPL_NPOS; g++) begin : g_cmp
      assign pass_thr[g] = (prio_flat[3*g +: 3] <= thr);
      assign lvl_eq[g]   = (prio_flat[3*g +: 3] == pwdata[2:0]);
   end

   // In-service blocks its own source, except externals zero and one in special nested mode in master mode.
   assign blocked = serv_v & ~((sfnm && master) ? `ISMPL_EXT01_POS : 11'h000);
   // Nothing is offered until the mode is known, so a slave never sees master layout.
   assign cand = pend_v & ~mask & ~blocked & pass_thr & {`ISMPL_NPOS{strap_done}};

   // Winner among the live requests.
   ismpl_pick u_pick_req (
      .cand      (cand),
      .prio_flat (prio_flat),
      .found     (req_found),
      .pos       (req_pos),
      .prio      (req_prio)
   );

   // Highest priority source now in service, for the generic end.
   ismpl_pick u_pick_srv (
      .cand      (serv_v),
      .prio_flat (prio_flat),
      .found     (srv_found),
      .pos       (srv_pos),
      .prio      ()
   );

   // APB decode.
   wire logic [7:0] idx      = paddr[9:2];
   wire logic       aligned  = (paddr[1:0] == 2'b00);
   wire logic       h_eoi    = aligned && (idx == `ISMPL_IDX_EOI);
   wire logic       h_poll   = aligned && (idx == `ISMPL_IDX_POLL);
   wire logic       h_poll_status_view = aligned && (idx == `ISMPL_IDX_POLL_STATUS_VIEW);
   wire logic       h_mask   = aligned && (idx == `ISMPL_IDX_MASK);
   wire logic       h_floor  = aligned && (idx == `ISMPL_IDX_FLOOR);
   wire logic       h_serv   = aligned && (idx == `ISMPL_IDX_SERV);
   wire logic       h_req    = aligned && (idx == `ISMPL_IDX_REQ);
   wire logic       h_cfg    = aligned && (idx == `ISMPL_IDX_CFG);
   wire logic       h_prlo   = aligned && (idx == `ISMPL_IDX_PRLO);
   wire logic       h_prhi   = aligned && (idx == `ISMPL_IDX_PRHI);
   wire logic       h_any    = h_eoi | h_poll | h_poll_status_view | h_mask | h_floor | h_serv | h_req | h_cfg | h_prlo | h_prhi;
   wire logic       h_ro     = h_poll | h_poll_status_view | h_serv | h_req;
   // Unmapped words and writes to read-only words answer with an error and change nothing.
   wire logic       dec_err  = !h_any || (pwrite && h_ro);
   wire logic       setup    = psel && !penable;
   wire logic       access   = psel && penable;
   wire logic       wr_ok    = access && pwrite && !err_q;
   wire logic       rd_poll  = access && !pwrite && h_poll;
   wire logic       rd_poll_status_view = access && !pwrite && h_poll_status_view;
   wire logic       wr_eoi   = wr_ok && h_eoi;

   // Poll word: pending flag at fifteen, winning type in the low five bits.
   wire logic [31:0] poll_word = {16'h0000, win_valid, 10'h000, win_type};
   wire logic [31:0] rd_word =
      (h_poll | h_poll_status_view) ? poll_word :
      h_mask  ? {21'h000000, mask} :
      h_floor ? {29'h00000000, thr} :
      h_serv  ? {21'h000000, serv_v} :
      h_req   ? {21'h000000, pend_v} :
      h_cfg   ? {29'h00000000, strap_done, master, sfnm} :
      h_prlo  ? {8'h00, prio_flat[23:0]} :
      h_prhi  ? {23'h000000, prio_flat[32:24]} : 32'h00000000;

   // Taking a source: core acknowledge of the shown winner, or a poll read.
   wire logic        ack_take  = irq_ack && win_valid;
   wire logic        poll_take = rd_poll && poll_hit && !err_q;
   ismpl_pkg::ismpl_vec_t ack_vec;
   ismpl_pkg::ismpl_vec_t poll_vec;
   assign ack_vec  = ack_take ? onehot(win_pos) : 11'h000;
   assign poll_vec = poll_take ? onehot(poll_pos) : 11'h000;
   wire logic [11:0] take_l    = unview(master, ack_vec | poll_vec);
   // Master timer unit is one position; the lowest pending timer is the one taken.
   wire logic [2:0]  t_first   = pend_t & ~(pend_t - 3'h1);
   wire logic [2:0]  take_t    = master ? (take_l[2:0] & t_first) : take_l[2:0];

   // End of interrupt: generic, specific by type, or slave by level.
   wire logic [4:0]  spec_off  = pwdata[4:0] - `ISMPL_TYPE_BASE;
   wire logic        spec_ok   = (spec_off < 5'(`ISMPL_NPOS));
   wire logic        gen_end   = pwdata[`ISMPL_GEN_END];
   ismpl_pkg::ismpl_vec_t spec_vec;
   ismpl_pkg::ismpl_vec_t clr_vec;
   assign spec_vec = spec_ok ? onehot(spec_off[3:0]) : 11'h000;
   assign clr_vec  = !wr_eoi ? 11'h000 :
                     !master ? lvl_eq :
                     gen_end ? (srv_found ? onehot(srv_pos) : 11'h000) : spec_vec;
   wire logic [11:0] clr_l     = unview(master, clr_vec);

   // Next lanes; a set in the same cycle as a clear wins.
   wire logic [10:2] set_o     = {serial_req, wdog_req, ext_req, dma_req} & (master ? 9'h1FF : `ISMPL_SLV_OTHER);
   wire logic [2:0]  next_pend_t = (pend_t & ~take_t) | timer_req;
   wire logic [10:2] next_pend_o = (pend_o & ~take_l[11:3]) | set_o;
   wire logic [2:0]  next_serv_t = (serv_t & ~clr_l[2:0]) | take_t;
   wire logic [10:2] next_serv_o = (serv_o & ~clr_l[11:3]) | take_l[11:3];

   // The strap passes three flops; after the settling count it is captured once stages two and three agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
         strap_s3 <= 1'b0;
      end else begin
         strap_s1 <= master_strap;
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
      end
   end

   // Strap capture loads the mode and the mask reset value of that mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_state <= ismpl_pkg::ISMPL_STRAP_WAIT;
         strap_cnt   <= 2'h0;
         master      <= 1'b1;
         mask        <= `ISMPL_MASK_RST_M;
      end else begin
         unique case (strap_state)
            ismpl_pkg::ISMPL_STRAP_WAIT: begin
               if (strap_cnt != `ISMPL_STRAP_WAIT) begin
                  strap_cnt <= strap_cnt + 2'h1;
               end else if (strap_s2 == strap_s3) begin
                  master      <= strap_s3;
                  mask        <= strap_s3 ? `ISMPL_MASK_RST_M : `ISMPL_MASK_RST_S;
                  strap_state <= ismpl_pkg::ISMPL_STRAP_DONE;
               end
            end
            ismpl_pkg::ISMPL_STRAP_DONE: begin
               if (wr_ok && h_mask) begin
                  mask <= pwdata[10:0] & (master ? `ISMPL_MASK_WR_M : `ISMPL_MASK_WR_S);
               end
            end
         endcase
      end
   end

   // Threshold, priorities and nested-mode enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr       <= `ISMPL_THR_RST;
         prio_flat <= `ISMPL_PRIO_RST;
         sfnm      <= 1'b0;
      end else begin
         if (wr_ok && h_floor) thr <= pwdata[2:0];
         if (wr_ok && h_prlo) prio_flat[23:0] <= pwdata[23:0];
         if (wr_ok && h_prhi) prio_flat[32:24] <= pwdata[8:0];
         if (wr_ok && h_cfg) sfnm <= pwdata[0];
      end
   end

   // Pending and in-service lanes; in-service starts clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_t <= 3'h0;
         pend_o <= 9'h000;
         serv_t <= 3'h0;
         serv_o <= 9'h000;
      end else begin
         pend_t <= next_pend_t;
         pend_o <= next_pend_o;
         serv_t <= next_serv_t;
         serv_o <= next_serv_o;
      end
   end

   // Winner is registered; the core and polling see it one cycle after the request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_valid <= 1'b0;
         win_pos   <= 4'h0;
         win_type  <= 5'h00;
      end else begin
         win_valid <= req_found;
         win_pos   <= req_pos;
         win_type  <= req_found ? 5'(`ISMPL_TYPE_BASE + {1'b0, req_pos}) : 5'h00;
      end
   end

   // Setup cycle captures read data, error and the poll target, so the access edge acts on what was read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata   <= 32'h00000000;
         err_q    <= 1'b0;
         poll_hit <= 1'b0;
         poll_pos <= 4'h0;
      end else if (setup) begin
         prdata   <= pwrite ? 32'h00000000 : rd_word;
         err_q    <= dec_err;
         poll_hit <= win_valid;
         poll_pos <= win_pos;
      end
   end

   // The core is requested with the registered winner and its type; a poll read can take it instead.
   assign irq_req  = win_valid;
   assign irq_type = win_type;
   assign pready   = access;
   assign pslverr  = access && err_q;

   property p_serv_zero_early;
      @(posedge pclk) disable iff (!presetn)
      !strap_done |-> (serv_v == 11'h000);
   endproperty
   a_serv_zero_early: assert property (p_serv_zero_early) else $error("in-service set before mode capture");

   property p_ack_sets_serv;
      @(posedge pclk) disable iff (!presetn)
      ack_take && !wr_eoi |=> ((serv_v & $past(ack_vec)) != 11'h000);
   endproperty
   a_ack_sets_serv: assert property (p_ack_sets_serv) else $error("acknowledge did not set in-service");

   property p_no_self;
      @(posedge pclk) disable iff (!presetn)
      win_valid && !sfnm |-> (($past(serv_v) & onehot(win_pos)) == 11'h000);
   endproperty
   a_no_self: assert property (p_no_self) else $error("request raised while in service");

   property p_thr;
      @(posedge pclk) disable iff (!presetn)
      req_found |-> (req_prio <= thr) ##1 (win_valid && win_pos == $past(req_pos));
   endproperty
   a_thr: assert property (p_thr) else $error("threshold or winner pass broken");

   property p_poll_flag;
      @(posedge pclk) disable iff (!presetn)
      (cand != 11'h000) |=> win_valid && (win_type == 5'(`ISMPL_TYPE_BASE + {1'b0, win_pos}));
   endproperty
   a_poll_flag: assert property (p_poll_flag) else $error("pending flag or type wrong");

   property p_poll_status_view_quiet;
      @(posedge pclk) disable iff (!presetn)
      rd_poll_status_view && !irq_ack |=> $stable(serv_t) && $stable(serv_o);
   endproperty
   a_poll_status_view_quiet: assert property (p_poll_status_view_quiet) else $error("poll status read changed in-service");

   property p_poll_take;
      @(posedge pclk) disable iff (!presetn)
      poll_take |=> ((serv_v & $past(poll_vec)) != 11'h000);
   endproperty
   a_poll_take: assert property (p_poll_take) else $error("poll read did not acknowledge");

   property p_spec_end;
      @(posedge pclk) disable iff (!presetn)
      wr_eoi && master && !gen_end && spec_ok && !ack_take |=> ((serv_v & $past(spec_vec)) == 11'h000);
   endproperty
   a_spec_end: assert property (p_spec_end) else $error("specific end left bit set");

   property p_level_end;
      @(posedge pclk) disable iff (!presetn)
      wr_eoi && !master && !ack_take |=> ((serv_v & $past(lvl_eq)) == 11'h000);
   endproperty
   a_level_end: assert property (p_level_end) else $error("level end left bit set");

   property p_mask_load;
      @(posedge pclk) disable iff (!presetn)
      $rose(strap_done) |-> (mask == (master ? `ISMPL_MASK_RST_M : `ISMPL_MASK_RST_S));
   endproperty
   a_mask_load: assert property (p_mask_load) else $error("mask reset value wrong for mode");

endmodule : ismpl_top

`default_nettype wire

// >>> ismpl_core_model.sv
// Purpose: Behavioural core that acknowledges the winning interrupt after a chosen delay.
// Assumes: irq_req and irq_type are registered on pclk.
// Notes: Needs at least three high cycles, so the one stale cycle after an acknowledge is never taken twice.
`timescale 1ns/1ps
`default_nettype none

module ismpl_core_model (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Controller side.
   input  wire logic       irq_req,
   input  wire logic [4:0] irq_type,
   output logic            irq_ack,
   // Test control and result.
   input  wire logic       ack_en,
   input  wire logic [1:0] ack_wait,
   output logic [4:0]      taken
);
   logic [2:0] cnt;  // Cycles the request has stood while acknowledges are allowed.

   // Count the standing request and answer with a one-cycle acknowledge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ack <= 1'b0;
         cnt     <= 3'h0;
         taken   <= 5'h00;
      end else if (irq_ack) begin
         irq_ack <= 1'b0;
         cnt     <= 3'h0;
         taken   <= irq_type;
      end else begin
         cnt     <= (ack_en && irq_req) ? cnt + 3'h1 : 3'h0;
         irq_ack <= ack_en && irq_req && (cnt == {1'b0, ack_wait} + 3'h2);
      end
   end
endmodule : ismpl_core_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench of the status, mask and poll logic in master mode, then in slave mode.
// Assumes: APB answers without wait states but the master still waits for pready.
// Notes: Watchdog and serial sources are tied low; the mode strap drops under a mid-run reset.
`timescale 1ns/1ps
`default_nettype none
`include "ismpl_params.svh"

module tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, irq_req, irq_ack, ack_en = 1'b0, strap = 1'b1;
   logic [2:0] timer_req = 3'h0;
   logic [1:0] dma_req = 2'h0, ack_wait = 2'h0;
   logic [4:0] irq_type, taken, ext_req = 5'h00;
   int bad_count = 0, cmp_count = 0;

   always #2 pclk = ~pclk;  // 250 MHz.

   ismpl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .master_strap(strap), .timer_req(timer_req), .dma_req(dma_req), .ext_req(ext_req),
      .wdog_req(1'b0), .serial_req(1'b0), .irq_req(irq_req), .irq_type(irq_type), .irq_ack(irq_ack));
   ismpl_core_model u_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_type(irq_type),
      .irq_ack(irq_ack), .ack_en(ack_en), .ack_wait(ack_wait), .taken(taken));

   // Compare and count; an unknown never matches.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One APB transfer: setup, then access held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string name);
      apb(1'b0, idx, 32'h0);
      chk(name, rd, exp);
      chk("slave error", {31'h0, err}, 32'h0);
   endtask : rchk

   // Let the core model take one interrupt, prompt or slow.
   task automatic core_take(input logic [1:0] w);
      ack_wait <= w; ack_en <= 1'b1;
      repeat (10) @(posedge pclk);
      ack_en <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : core_take

   task automatic stop_test;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   initial begin
      #40000;
      bad_count++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      rchk(`ISMPL_IDX_MASK, 32'h7FD, "mask reset");
      rchk(`ISMPL_IDX_FLOOR, 32'h7, "floor reset");
      rchk(`ISMPL_IDX_SERV, 32'h0, "service reset");
      $display("test reset values done");
      apb(1'b1, `ISMPL_IDX_MASK, 32'h7F8);
      rchk(`ISMPL_IDX_MASK, 32'h7F8, "mask write");
      dma_req <= 2'h1; @(posedge pclk); dma_req <= 2'h0; repeat (3) @(posedge pclk);
      rchk(`ISMPL_IDX_REQ, 32'h004, "request dma0");
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h800A, "poll status");
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h800A, "poll status again");
      apb(1'b1, `ISMPL_IDX_FLOOR, 32'h6);
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h0, "floor six");
      chk("irq request low", {31'h0, irq_req}, 32'h0);
      apb(1'b1, `ISMPL_IDX_FLOOR, 32'h7);
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h800A, "floor seven");
      chk("irq request high", {31'h0, irq_req}, 32'h1);
      $display("test mask and floor done");
      core_take(2'h0);
      chk("taken type", {27'h0, taken}, 32'h0A);
      rchk(`ISMPL_IDX_SERV, 32'h004, "service dma0");
      rchk(`ISMPL_IDX_REQ, 32'h0, "request cleared");
      dma_req <= 2'h1; @(posedge pclk); dma_req <= 2'h0; repeat (3) @(posedge pclk);
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h0, "blocked by service");
      apb(1'b1, `ISMPL_IDX_EOI, 32'h000A);
      rchk(`ISMPL_IDX_SERV, 32'h0, "specific end");
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h800A, "released request");
      core_take(2'h3);
      rchk(`ISMPL_IDX_SERV, 32'h004, "service slow ack");
      apb(1'b1, `ISMPL_IDX_EOI, 32'h8000);
      rchk(`ISMPL_IDX_SERV, 32'h0, "generic end");
      $display("test acknowledge and end done");
      timer_req <= 3'h4; @(posedge pclk); timer_req <= 3'h0; repeat (3) @(posedge pclk);
      rchk(`ISMPL_IDX_POLL, 32'h8008, "poll read");
      // Polling only marks service; the bench itself plays the handler here.
      rchk(`ISMPL_IDX_SERV, 32'h001, "timer or service");
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h0, "poll advanced");
      apb(1'b1, `ISMPL_IDX_EOI, 32'h0008);
      rchk(`ISMPL_IDX_SERV, 32'h0, "timer end");
      $display("test poll done");
      // Special nested mode lets external input zero request again while in service.
      apb(1'b1, `ISMPL_IDX_CFG, 32'h1);
      apb(1'b1, `ISMPL_IDX_MASK, 32'h7E8);
      ext_req <= 5'h01; @(posedge pclk); ext_req <= 5'h00; repeat (3) @(posedge pclk);
      core_take(2'h0);
      rchk(`ISMPL_IDX_SERV, 32'h010, "service ext0");
      ext_req <= 5'h01; @(posedge pclk); ext_req <= 5'h00; repeat (3) @(posedge pclk);
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h800C, "nested ext0");
      $display("test nested mode done");
      apb(1'b1, `ISMPL_IDX_POLL_STATUS_VIEW, 32'h8000);
      chk("write read-only error", {31'h0, err}, 32'h1);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      $display("test refusals done");
      // Mid-run reset with the strap low brings the block up in slave mode.
      presetn <= 1'b0; strap <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      rchk(`ISMPL_IDX_MASK, 32'h03D, "slave mask reset");
      rchk(`ISMPL_IDX_SERV, 32'h0, "slave service reset");
      timer_req <= 3'h7; dma_req <= 2'h1; @(posedge pclk);
      timer_req <= 3'h0; dma_req <= 2'h0; repeat (3) @(posedge pclk);
      rchk(`ISMPL_IDX_REQ, 32'h035, "slave request");
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h0, "slave all masked");
      apb(1'b1, `ISMPL_IDX_MASK, 32'h0);
      // Timer two gets priority three; the rest stay at seven.
      apb(1'b1, `ISMPL_IDX_PRLO, 32'h00FDFFFF);
      rchk(`ISMPL_IDX_POLL_STATUS_VIEW, 32'h800D, "lowest value wins");
      apb(1'b1, `ISMPL_IDX_FLOOR, 32'h3);
      core_take(2'h0);
      chk("slave taken", {27'h0, taken}, 32'h0D);
      rchk(`ISMPL_IDX_SERV, 32'h020, "slave service timer2");
      rchk(`ISMPL_IDX_REQ, 32'h015, "slave ack clears");
      apb(1'b1, `ISMPL_IDX_EOI, 32'h3);
      rchk(`ISMPL_IDX_SERV, 32'h0, "slave level end");
      $display("test slave mode done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
